// file: obm_pkg.sv
// ==========================================================
// Overview of operation
// - Memory write strobe low in memory writes
// - Memory read strobe low in memory reads
// - Only primary processor drives I/O strobes
// - Cycle type stable before latch pulse ends
// - Main board alone makes DRAM cycle trigger
// - Latch pulse only for primary processor cycles
// - Carry 8 MHz bus clock on bus
// - Byte lanes from upper enable and bit0
// - Two wait states for I/O 300-3FF
// - Low page qualifier: I/O, bits 15:10 zero
// - Main board never uses I/O 380-3FF
// - Masked option interrupts map to fixed types
// - Grant after cycle end, no lock, priority
// - Refresh flag and rotating row modulo 256
// - Parity error raises NMI, records source
// - Baud reference clock 2.458 MHz, 50% duty
// - Bus reset at power-up, button, keyboard
// - Main board transfers use lower byte only
package obm_pkg;

  // ==========================================================
  // Clock rates and derived timing.
  localparam longint CLK_HZ = 250000000;
  localparam longint BUS_HZ = 8000000;
  localparam longint BAUD_HZ = 2458000;
  localparam int CLK_NS = int'(1000000000 / CLK_HZ);
  localparam int BUS_T_NS = int'(1000000000 / BUS_HZ);
  localparam int T_CYC = (BUS_T_NS + CLK_NS - 1) / CLK_NS;
  localparam int BASE_T = 2;
  localparam int IO_WAIT_T = 2;
  localparam int REFRESH_NS = 15000;
  localparam int REF_CYC = REFRESH_NS / CLK_NS;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RST_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Phase accumulators for the derived clocks (toggle at twice the rate).
  localparam int PHASE_W = 24;
  localparam logic [23:0] BAUD_INC = 24'((2 * BAUD_HZ * (64'h1 << PHASE_W)) / CLK_HZ);
  localparam logic [23:0] BUS_INC = 24'((2 * BUS_HZ * (64'h1 << PHASE_W)) / CLK_HZ);

  // ==========================================================
  // I/O address windows.
  localparam logic [7:0] SLOW_IO_PAGE = 8'h03;
  localparam logic [9:0] VENDOR_IO_BASE = 10'h380;

  // ==========================================================
  // Bit positions in the synchronised pin vector.
  localparam int AI_WAIT = 0;
  localparam int AI_REQ = 1;
  localparam int AI_IRQ = 5;
  localparam int AI_PERR = 12;
  localparam int AI_MWR = 13;
  localparam int AI_MRD = 14;
  localparam int AI_PG = 15;
  localparam int AI_BTN = 16;
  localparam int AI_KBD = 17;
  localparam int AI_UBE = 18;
  localparam int AI_A0 = 19;
  localparam int AW = 20;
  localparam logic [19:0] ASYNC_IDLE = 20'h47FFF;

  // ==========================================================
  // Interrupt types, option line order 0,1,2,4,6,9,11.
  localparam logic [7:0] IRQ_TYPE [7] = '{8'h60, 8'h61, 8'h62, 8'h64, 8'h66, 8'h69, 8'h68};

  // ==========================================================
  // Byte-lane access kinds.
  localparam logic [1:0] KIND_EVEN8 = 2'h0;
  localparam logic [1:0] KIND_ODD8 = 2'h1;
  localparam logic [1:0] KIND_EVEN16 = 2'h2;
  localparam logic [1:0] KIND_RSVD = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ALE = 3'h1,
    ST_CMD = 3'h2,
    ST_REF = 3'h3,
    ST_GRANT = 3'h4
  } obm_state_t;

  // Decodes the byte lanes of an access from upper enable and address bit 0.
  function automatic logic [1:0] obm_lane_kind(input logic ube_n, input logic a0);
    return {~ube_n, a0};
  endfunction : obm_lane_kind

endpackage : obm_pkg

// file: obm_clkgen.sv
`timescale 1ns/10ps
// ==========================================================
// Phase-accumulator clock generator with near 50% duty.
module obm_clkgen
  import obm_pkg::*;
#(
  parameter logic [23:0] INC = BAUD_INC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Generated clock.
  output logic clk_out
);

  typedef struct packed {
    logic [23:0] acc;
    logic out;
  } obm_gen_t;

  obm_gen_t q_r;
  obm_gen_t q_nxt;
  logic [24:0] sum;

  // The output toggles on every accumulator carry.
  always_comb begin
    q_nxt = q_r;
    sum = {1'b0, q_r.acc} + {1'b0, INC};
    q_nxt.acc = sum[23:0];
    if (sum[24]) begin
      q_nxt.out = ~q_r.out;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign clk_out = q_r.out;

endmodule : obm_clkgen

// file: obm_bus.sv
`timescale 1ns/10ps
// ==========================================================
// Main-board side of the option expansion bus.
module obm_bus
  import obm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Primary processor request.
  input wire logic pri_req,
  input wire logic pri_mem,
  input wire logic pri_write,
  input wire logic pri_lock,
  input wire logic [19:0] pri_addr,
  input wire logic [7:0] pri_wdata,
  output logic pri_ack,
  // Secondary processor request, memory only.
  input wire logic sec_req,
  input wire logic sec_write,
  input wire logic [19:0] sec_addr,
  input wire logic [7:0] sec_wdata,
  output logic sec_ack,
  // Read data returned to either processor.
  output logic [7:0] rdata,
  // Address pins.
  output logic [19:0] addr_out,
  output logic addr_oe,
  input wire logic addr_bit0,
  input wire logic upper_byte_enable_n,
  output logic upper_byte_enable_n_out,
  // Data lanes, one enable per byte.
  output logic [15:0] data_lane_out,
  output logic [1:0] data_lane_oe,
  input wire logic [15:0] data_lane,
  // Strobes and cycle signals.
  input wire logic mem_write_strobe_n,
  input wire logic mem_read_strobe_n,
  output logic mem_write_strobe_n_out,
  output logic mem_read_strobe_n_out,
  output logic mem_strobe_oe,
  output logic io_write_strobe_n,
  output logic io_read_strobe_n,
  output logic mem_not_io,
  output logic dram_cycle_trigger_n,
  output logic addr_latch_pulse,
  output logic low_io_page_qualifier_n,
  output logic onboard_io_sel,
  // Wait line, open drain.
  input wire logic wait_request_n,
  output logic wait_request_n_out,
  output logic wait_request_oe,
  // Interrupts.
  input wire logic [6:0] option_irq_n,
  input wire logic [6:0] irq_enable,
  output logic irq_request,
  output logic [7:0] irq_type,
  // Bus mastership.
  input wire logic [3:0] master_request_n,
  output logic [3:0] master_grant_n,
  output logic [1:0] master_access_kind,
  // Refresh.
  output logic refresh_cycle_n,
  // Parity.
  input wire logic parity_error_n,
  input wire logic onboard_parity_error,
  input wire logic nmi_clear,
  output logic nmi,
  output logic parity_offboard,
  // Clocks and reset out.
  output logic bus_clk,
  output logic baud_reference_clock,
  input wire logic power_good,
  input wire logic reset_button,
  input wire logic keyboard_break,
  output logic system_reset_n
);

  typedef struct packed {
    logic [AW-1:0] sync1;
    logic [AW-1:0] sync2;
    logic [AW-1:0] sync3;
    logic [AW-1:0] filt;
    obm_state_t state;
    logic [7:0] cnt;
    logic [7:0] len;
    logic src_sec;
    logic cyc_mem;
    logic cyc_wr;
    logic slow;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic ale;
    logic mio;
    logic trig_n;
    logic mrd_n;
    logic mwr_n;
    logic iord_n;
    logic iowr_n;
    logic qual_n;
    logic io_sel;
    logic aoe;
    logic doe;
    logic soe;
    logic woe;
    logic ref_n;
    logic [7:0] row;
    logic [11:0] ref_cnt;
    logic ref_due;
    logic [3:0] grant_n;
    logic [1:0] gidx;
    logic [1:0] kind;
    logic pri_ack;
    logic sec_ack;
    logic [7:0] rdata;
    logic irq_req;
    logic [7:0] irq_type;
    logic nmi;
    logic perr_off;
    logic [7:0] rst_cnt;
    logic sys_rst_n;
  } obm_bus_st_t;

  obm_bus_st_t q_r;
  obm_bus_st_t q_nxt;
  logic [AW-1:0] pins;
  logic [AW-1:0] agree;
  logic [AW-1:0] f;
  logic [3:0] req_act;
  logic [6:0] pend;
  logic [7:0] io_len;

  // ==========================================================
  // Pin gathering and helper decoding.
  assign pins = {addr_bit0, upper_byte_enable_n, keyboard_break, reset_button, power_good,
                 mem_read_strobe_n, mem_write_strobe_n, parity_error_n, option_irq_n,
                 master_request_n, wait_request_n};
  assign f = q_r.filt;
  assign req_act = ~f[AI_REQ +: 4];
  assign pend = ~f[AI_IRQ +: 7] & irq_enable;

  // Returns the type of the first pending line, lowest line number first.
  function automatic logic [7:0] irq_pick(input logic [6:0] p);
    logic [7:0] t;
    t = 8'h00;
    for (int i = 6; i >= 0; i--) begin
      if (p[i]) begin
        t = IRQ_TYPE[i];
      end
    end
    return t;
  endfunction : irq_pick

  // Returns the highest-priority pending request index; pair 0 wins.
  function automatic logic [1:0] req_pick(input logic [3:0] r);
    logic [1:0] k;
    k = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (r[i]) begin
        k = 2'(i);
      end
    end
    return k;
  endfunction : req_pick

  // ==========================================================
  // Next-state logic.
  always_comb begin
    q_nxt = q_r;
    q_nxt.pri_ack = 1'b0;
    q_nxt.sec_ack = 1'b0;
    // Three-stage pin capture; a change counts once stages two and three agree.
    q_nxt.sync1 = pins;
    q_nxt.sync2 = q_r.sync1;
    q_nxt.sync3 = q_r.sync2;
    agree = ~(q_r.sync2 ^ q_r.sync3);
    q_nxt.filt = (agree & q_r.sync3) | (~agree & q_r.filt);
    // Refresh interval timer; a due refresh is kept until served.
    if (q_r.ref_cnt == 12'(REF_CYC - 1)) begin
      q_nxt.ref_cnt = 12'h000;
      q_nxt.ref_due = 1'b1;
    end else begin
      q_nxt.ref_cnt = q_r.ref_cnt + 12'h001;
    end
    // Interrupt request and vector type.
    q_nxt.irq_req = |pend;
    q_nxt.irq_type = irq_pick(pend);
    // Parity failure: the set wins over a clear in the same cycle.
    if (nmi_clear) begin
      q_nxt.nmi = 1'b0;
    end
    if (!f[AI_PERR] || onboard_parity_error) begin
      q_nxt.nmi = 1'b1;
      q_nxt.perr_off = !f[AI_PERR];
    end
    // Bus reset pulse after supply good, button or keyboard break.
    if (!f[AI_PG] || (q_nxt.filt[AI_PG] && !f[AI_PG]) ||
        (q_nxt.filt[AI_BTN] && !f[AI_BTN]) || (q_nxt.filt[AI_KBD] && !f[AI_KBD])) begin
      q_nxt.rst_cnt = 8'(RST_CYC);
    end else if (q_r.rst_cnt != 8'h00) begin
      q_nxt.rst_cnt = q_r.rst_cnt - 8'h01;
    end
    q_nxt.sys_rst_n = (q_nxt.rst_cnt == 8'h00);
    // Bus cycle sequencer.
    case (q_r.state)
      ST_IDLE: begin
        q_nxt.cnt = 8'h00;
        if (q_r.ref_due) begin
          // Refresh read with the rotating row address.
          q_nxt.state = ST_REF;
          q_nxt.ref_due = 1'b0;
          q_nxt.ref_n = 1'b0;
          q_nxt.addr = {12'h000, q_r.row};
          q_nxt.aoe = 1'b1;
          q_nxt.mio = 1'b1;
          q_nxt.trig_n = 1'b0;
          q_nxt.mrd_n = 1'b0;
        end else if (|req_act && !pri_lock) begin
          // Bus is free between cycles and no lock is held.
          q_nxt.state = ST_GRANT;
          q_nxt.gidx = req_pick(req_act);
          q_nxt.grant_n = ~(4'h1 << req_pick(req_act));
          q_nxt.aoe = 1'b0;
          q_nxt.soe = 1'b0;
        end else if (pri_req) begin
          q_nxt.state = ST_ALE;
          q_nxt.src_sec = 1'b0;
          q_nxt.cyc_mem = pri_mem;
          q_nxt.cyc_wr = pri_write;
          q_nxt.addr = pri_addr;
          q_nxt.wdata = pri_wdata;
          q_nxt.aoe = 1'b1;
          q_nxt.ale = 1'b1;
          q_nxt.mio = pri_mem;
          q_nxt.trig_n = !pri_mem;
          q_nxt.qual_n = !(!pri_mem && pri_addr[15:10] == 6'h00);
          q_nxt.io_sel = !pri_mem && pri_addr[15:10] == 6'h00 &&
                         pri_addr[9:0] < VENDOR_IO_BASE;
          q_nxt.slow = !pri_mem && pri_addr[15:8] == SLOW_IO_PAGE;
          q_nxt.len = (!pri_mem && pri_addr[15:8] == SLOW_IO_PAGE) ?
                      8'(T_CYC * (BASE_T + IO_WAIT_T)) : 8'(T_CYC * BASE_T);
        end else if (sec_req) begin
          // Secondary cycles skip the latch pulse and never touch I/O.
          q_nxt.state = ST_CMD;
          q_nxt.src_sec = 1'b1;
          q_nxt.cyc_mem = 1'b1;
          q_nxt.cyc_wr = sec_write;
          q_nxt.addr = sec_addr;
          q_nxt.wdata = sec_wdata;
          q_nxt.aoe = 1'b1;
          q_nxt.mio = 1'b1;
          q_nxt.trig_n = 1'b0;
          q_nxt.slow = 1'b0;
          q_nxt.len = 8'(T_CYC * BASE_T);
          q_nxt.mwr_n = !sec_write;
          q_nxt.mrd_n = sec_write;
          q_nxt.doe = sec_write;
        end
      end
      ST_ALE: begin
        q_nxt.cnt = q_r.cnt + 8'h01;
        if (q_r.cnt == 8'(T_CYC - 1)) begin
          q_nxt.state = ST_CMD;
          q_nxt.cnt = 8'h00;
          q_nxt.ale = 1'b0;
          q_nxt.mwr_n = !(q_r.cyc_mem && q_r.cyc_wr);
          q_nxt.mrd_n = !(q_r.cyc_mem && !q_r.cyc_wr);
          q_nxt.iowr_n = !(!q_r.cyc_mem && q_r.cyc_wr);
          q_nxt.iord_n = !(!q_r.cyc_mem && !q_r.cyc_wr);
          q_nxt.doe = q_r.cyc_wr;
          q_nxt.woe = q_r.slow;
        end
      end
      ST_CMD: begin
        if (q_r.cnt == 8'(T_CYC * IO_WAIT_T - 1)) begin
          q_nxt.woe = 1'b0;
        end
        if (q_r.cnt < q_r.len - 8'h01) begin
          q_nxt.cnt = q_r.cnt + 8'h01;
        end else if (f[AI_WAIT] && !q_r.woe) begin
          // Cycle ends only once the wait line is free.
          q_nxt.state = ST_IDLE;
          q_nxt.mwr_n = 1'b1;
          q_nxt.mrd_n = 1'b1;
          q_nxt.iowr_n = 1'b1;
          q_nxt.iord_n = 1'b1;
          q_nxt.trig_n = 1'b1;
          q_nxt.qual_n = 1'b1;
          q_nxt.io_sel = 1'b0;
          q_nxt.aoe = 1'b0;
          q_nxt.doe = 1'b0;
          q_nxt.mio = 1'b1;
          q_nxt.rdata = q_r.cyc_wr ? q_r.rdata : data_lane[7:0];
          q_nxt.pri_ack = !q_r.src_sec;
          q_nxt.sec_ack = q_r.src_sec;
        end
      end
      ST_REF: begin
        q_nxt.cnt = q_r.cnt + 8'h01;
        if (q_r.cnt == 8'(T_CYC * BASE_T - 1)) begin
          q_nxt.state = ST_IDLE;
          q_nxt.ref_n = 1'b1;
          q_nxt.row = q_r.row + 8'h01;
          q_nxt.mrd_n = 1'b1;
          q_nxt.trig_n = 1'b1;
          q_nxt.aoe = 1'b0;
        end
      end
      ST_GRANT: begin
        // Trigger follows the master's memory strobes.
        q_nxt.trig_n = f[AI_MWR] && f[AI_MRD];
        q_nxt.kind = obm_lane_kind(f[AI_UBE], f[AI_A0]);
        if (!req_act[q_r.gidx]) begin
          q_nxt.state = ST_IDLE;
          q_nxt.grant_n = 4'hF;
          q_nxt.trig_n = 1'b1;
          q_nxt.soe = 1'b1;
        end
      end
      default: begin
        q_nxt.state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= '0;
      q_r.sync1 <= ASYNC_IDLE;
      q_r.sync2 <= ASYNC_IDLE;
      q_r.sync3 <= ASYNC_IDLE;
      q_r.filt <= ASYNC_IDLE;
      q_r.state <= ST_IDLE;
      q_r.mio <= 1'b1;
      q_r.trig_n <= 1'b1;
      q_r.mrd_n <= 1'b1;
      q_r.mwr_n <= 1'b1;
      q_r.iord_n <= 1'b1;
      q_r.iowr_n <= 1'b1;
      q_r.qual_n <= 1'b1;
      q_r.soe <= 1'b1;
      q_r.ref_n <= 1'b1;
      q_r.grant_n <= 4'hF;
      q_r.rst_cnt <= 8'(RST_CYC);
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // Derived bus clock and baud reference.
  obm_clkgen #(.INC(BUS_INC)) u_bus_clk (
    .clk(clk),
    .rst(rst),
    .clk_out(bus_clk)
  );

  obm_clkgen #(.INC(BAUD_INC)) u_baud_clk (
    .clk(clk),
    .rst(rst),
    .clk_out(baud_reference_clock)
  );

  // Outputs taken straight from the state register; the wait pin drive is a constant low.
  assign pri_ack = q_r.pri_ack;
  assign sec_ack = q_r.sec_ack;
  assign rdata = q_r.rdata;
  assign addr_out = q_r.addr;
  assign addr_oe = q_r.aoe;
  assign upper_byte_enable_n_out = q_r.soe;
  assign data_lane_out = {8'h00, q_r.wdata};
  assign data_lane_oe = {1'b0, q_r.doe};
  assign mem_write_strobe_n_out = q_r.mwr_n;
  assign mem_read_strobe_n_out = q_r.mrd_n;
  assign mem_strobe_oe = q_r.soe;
  assign io_write_strobe_n = q_r.iowr_n;
  assign io_read_strobe_n = q_r.iord_n;
  assign mem_not_io = q_r.mio;
  assign dram_cycle_trigger_n = q_r.trig_n;
  assign addr_latch_pulse = q_r.ale;
  assign low_io_page_qualifier_n = q_r.qual_n;
  assign onboard_io_sel = q_r.io_sel;
  assign wait_request_n_out = 1'b0;
  assign wait_request_oe = q_r.woe;
  assign irq_request = q_r.irq_req;
  assign irq_type = q_r.irq_type;
  assign master_grant_n = q_r.grant_n;
  assign master_access_kind = q_r.kind;
  assign refresh_cycle_n = q_r.ref_n;
  assign nmi = q_r.nmi;
  assign parity_offboard = q_r.perr_off;
  assign system_reset_n = q_r.sys_rst_n;

  // ==========================================================
  // Checks. Helper counts how long an I/O strobe stays low.
  always_ff @(posedge clk) begin
    if (rst) begin
      io_len <= 8'h00;
    end else if (!q_r.iord_n || !q_r.iowr_n) begin
      io_len <= io_len + 8'h01;
    end else begin
      io_len <= 8'h00;
    end
  end

  sequence s_pulse_ends;
    $fell(q_r.ale);
  endsequence

  property p_ale_primary;
    @(posedge clk) disable iff (rst) q_r.src_sec |-> !q_r.ale;
  endproperty
  a_ale_primary: assert property (p_ale_primary) else $error("Latch pulse in secondary cycle.");

  property p_io_primary;
    @(posedge clk) disable iff (rst)
      (!q_r.iord_n || !q_r.iowr_n) |-> (!q_r.src_sec && !q_r.cyc_mem && q_r.grant_n == 4'hF);
  endproperty
  a_io_primary: assert property (p_io_primary) else $error("I/O strobe outside primary I/O.");

  property p_type_stable;
    @(posedge clk) disable iff (rst) s_pulse_ends |-> ($stable(q_r.mio) && q_r.mio == q_r.cyc_mem);
  endproperty
  a_type_stable: assert property (p_type_stable) else $error("Cycle type moved at latch end.");

  property p_qualifier;
    @(posedge clk) disable iff (rst) !q_r.qual_n |-> (!q_r.mio && q_r.addr[15:10] == 6'h00);
  endproperty
  a_qualifier: assert property (p_qualifier) else $error("Qualifier outside low I/O page.");

  property p_slow_io;
    @(posedge clk) disable iff (rst)
      ($rose(q_r.iord_n & q_r.iowr_n) && q_r.slow) |-> io_len >= 8'(T_CYC * (BASE_T + IO_WAIT_T));
  endproperty
  a_slow_io: assert property (p_slow_io) else $error("Slow I/O cycle too short.");

  property p_row_step;
    @(posedge clk) disable iff (rst) $rose(q_r.ref_n) |-> q_r.row == 8'($past(q_r.row) + 8'h01);
  endproperty
  a_row_step: assert property (p_row_step) else $error("Refresh row did not advance.");

  property p_grant_free;
    @(posedge clk) disable iff (rst)
      $fell(&q_r.grant_n) |-> ($past(q_r.state) == ST_IDLE && !$past(pri_lock));
  endproperty
  a_grant_free: assert property (p_grant_free) else $error("Grant during cycle or lock.");

  property p_parity_nmi;
    @(posedge clk) disable iff (rst) $fell(q_r.filt[AI_PERR]) |=> (q_r.nmi && q_r.perr_off);
  endproperty
  a_parity_nmi: assert property (p_parity_nmi) else $error("Parity error without NMI.");

  property p_kbd_reset;
    @(posedge clk) disable iff (rst) $rose(q_r.filt[AI_KBD]) |=> !q_r.sys_rst_n [*2];
  endproperty
  a_kbd_reset: assert property (p_kbd_reset) else $error("Keyboard break gave no reset.");

  property p_master_trigger;
    @(posedge clk) disable iff (rst)
      (q_r.state == ST_GRANT && !q_r.filt[AI_MRD] && !$fell(q_r.filt[AI_REQ + 0])) |=>
        (!q_r.trig_n || q_r.state == ST_IDLE);
  endproperty
  a_master_trigger: assert property (p_master_trigger) else $error("No trigger for master.");

endmodule : obm_bus

// file: obm_opt_board.sv
`timescale 1ns/10ps
// ==========================================================
// Option board master model; it has no I/O strobe drivers.
module obm_opt_board (
  // Clock and bench controls.
  input wire logic clk,
  input wire logic want_bus,
  input wire logic fault,
  // Bus side.
  input wire logic [3:0] master_grant_n,
  output logic [3:0] master_request_n,
  output logic mrd_n,
  output logic mrd_oe,
  output logic parity_error_n
);
  // Strobe is driven only while granted and released before the request drops.
  always_ff @(posedge clk) begin
    master_request_n <= {3'h7, ~(want_bus | mrd_oe)};
    mrd_oe <= want_bus & ~master_grant_n[0];
    mrd_n <= ~(want_bus & ~master_grant_n[0]);
    parity_error_n <= ~fault;
  end
endmodule : obm_opt_board

// file: tb_option_bus_main_board_side.sv
`timescale 1ns/10ps
// ==========================================================
// Bench for the main-board side of the option bus.
module tb_option_bus_main_board_side import obm_pkg::*;;
  // Driven inputs.
  logic clk = 1'h0, rst = 1'h1, pri_req = 1'h0, pri_mem = 1'h0, pri_write = 1'h0;
  logic pri_lock = 1'h0, sec_req = 1'h0, sec_write = 1'h0, ube_n = 1'h1, a0 = 1'h0;
  logic want = 1'h0, fault = 1'h0, nmi_clear = 1'h0, mio_ale;
  logic stall = 1'h0, onb = 1'h0, kbd = 1'h0, btn = 1'h0;
  logic [19:0] pri_addr = 20'h0, sec_addr = 20'h0;
  logic [7:0] wd = 8'hA5;
  logic [8:0] seen;
  logic [6:0] irq_n = 7'h7F, irq_en = 7'h00;
  int miscompares = 0, total_checks = 0, cyc = 0, n, k, wcnt = 0;
  // Design outputs and resolved wires.
  wire pri_ack, sec_ack, soe, mwr_o, mrd_o, iowr_n, iord_n, mio, trig_n, ale, qual_n, sel;
  wire wait_oe, irq_req, nmi, poff, sys_rst_n, ref_n, pb_oe, pb_mrd, perr_n;
  wire [7:0] irq_type, rd;
  wire [19:0] addr_out;
  wire [1:0] kind;
  wire [3:0] req_n, gnt_n;
  wire mrd_w = soe ? mrd_o : (pb_oe ? pb_mrd : 1'h1);
  wire mwr_w = soe ? mwr_o : 1'h1;
  wire wait_w = ~(wait_oe | (wcnt > 0));
  // Option board decode of its I/O slot at 380h from qualifier and bits 9:2.
  wire io_hit = !qual_n && addr_out[9:2] == 8'hE0;
  obm_bus uut (.clk(clk), .rst(rst), .pri_req(pri_req), .pri_mem(pri_mem),
    .pri_write(pri_write), .pri_lock(pri_lock), .pri_addr(pri_addr), .pri_wdata(wd),
    .pri_ack(pri_ack), .sec_req(sec_req), .sec_write(sec_write), .sec_addr(sec_addr),
    .sec_wdata(wd), .sec_ack(sec_ack), .rdata(rd), .addr_out(addr_out), .addr_oe(),
    .addr_bit0(a0), .upper_byte_enable_n(ube_n), .upper_byte_enable_n_out(),
    .data_lane_out(), .data_lane_oe(), .data_lane(16'h5A3C), .mem_write_strobe_n(mwr_w),
    .mem_read_strobe_n(mrd_w), .mem_write_strobe_n_out(mwr_o), .mem_read_strobe_n_out(mrd_o),
    .mem_strobe_oe(soe), .io_write_strobe_n(iowr_n), .io_read_strobe_n(iord_n),
    .mem_not_io(mio), .dram_cycle_trigger_n(trig_n), .addr_latch_pulse(ale),
    .low_io_page_qualifier_n(qual_n), .onboard_io_sel(sel), .wait_request_n(wait_w),
    .wait_request_n_out(), .wait_request_oe(wait_oe), .option_irq_n(irq_n),
    .irq_enable(irq_en), .irq_request(irq_req), .irq_type(irq_type),
    .master_request_n(req_n), .master_grant_n(gnt_n), .master_access_kind(kind),
    .refresh_cycle_n(ref_n), .parity_error_n(perr_n), .onboard_parity_error(onb),
    .nmi_clear(nmi_clear), .nmi(nmi), .parity_offboard(poff), .bus_clk(),
    .baud_reference_clock(), .power_good(1'h1), .reset_button(btn),
    .keyboard_break(kbd), .system_reset_n(sys_rst_n));
  obm_opt_board pb (.clk(clk), .want_bus(want), .fault(fault), .master_grant_n(gnt_n),
    .master_request_n(req_n), .mrd_n(pb_mrd), .mrd_oe(pb_oe), .parity_error_n(perr_n));
  // Clock and hang guard.
  always #2 clk = ~clk;
  // Slow option memory pulls wait from the latch pulse, then lets go after 100 cycles.
  always @(posedge clk) wcnt <= (stall && ale) ? 100 : ((wcnt > 0) ? wcnt - 1 : 0);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // One processor transfer; records which bus signals were seen active.
  task automatic xfer(input logic sec, input logic mem, input logic wr, input logic [19:0] a,
                      input int ncyc);
    @(posedge clk);
    if (sec) begin
      sec_req <= 1'h1;
      sec_write <= wr;
      sec_addr <= a;
    end else begin
      pri_req <= 1'h1;
      pri_mem <= mem;
      pri_write <= wr;
      pri_addr <= a;
    end
    seen = 9'h000;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      #1;
      if (ale && !seen[0]) mio_ale = mio;
      seen |= {io_hit, sel, ~qual_n, ~wait_w, ~mrd_w, ~mwr_w, ~iowr_n, ~iord_n, ale};
      if (pri_ack | sec_ack) break;
    end
    chk(8'(n), 8'(ncyc));
    pri_req <= 1'h0;
    sec_req <= 1'h0;
  endtask : xfer
  task automatic t_mem;
    xfer(1'h0, 1'h1, 1'h1, 20'h12344, T_CYC * (1 + BASE_T));
    chk(mio_ale, 1);
    chk(seen[3:0], 8'h9);
    chk(seen[5], 0);
    xfer(1'h1, 1'h1, 1'h0, 20'h0ABCD, T_CYC * BASE_T);
    chk(seen[4:0], 8'h10);
    chk(rd, 8'h3C);
    // Latch phase, 100 held wait cycles, then the pin filter and the closing edge.
    stall <= 1'h1;
    xfer(1'h0, 1'h1, 1'h0, 20'h12345, T_CYC + 105);
    stall <= 1'h0;
  endtask : t_mem
  task automatic t_io;
    logic [19:0] ta [4];
    logic [1:0] te [4];
    ta = '{20'h002FF, 20'h00300, 20'h00380, 20'h00C00};
    te = '{2'h2, 2'h3, 2'h3, 2'h0};
    for (k = 0; k < 4; k++) begin
      xfer(1'h0, 1'h0, k[0], ta[k], T_CYC * (1 + BASE_T + (te[k][0] ? IO_WAIT_T : 0)));
      chk(mio_ale, 0);
      chk(seen[6:5], te[k]);
      chk(seen[2:1], k[0] ? 8'h2 : 8'h1);
      chk(seen[7], k < 2);
      chk(seen[8], k == 2);
    end
  endtask : t_io
  task automatic t_master;
    logic [1:0] ek [4];
    ek = '{KIND_EVEN16, KIND_RSVD, KIND_EVEN8, KIND_ODD8};
    // A locked instruction holds the grant off.
    @(posedge clk);
    pri_lock <= 1'h1;
    want <= 1'h1;
    repeat (20) @(posedge clk);
    #1;
    chk(gnt_n, 8'hF);
    @(posedge clk);
    pri_lock <= 1'h0;
    for (n = 0; n < 200 && gnt_n[0] !== 1'h0; n++) @(posedge clk);
    #1;
    chk(gnt_n, 8'hE);
    repeat (12) @(posedge clk);
    #1;
    chk(trig_n, 0);
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      ube_n <= k[1];
      a0 <= k[0];
      repeat (8) @(posedge clk);
      #1;
      chk(kind, ek[k]);
    end
    want <= 1'h0;
    repeat (20) @(posedge clk);
    #1;
    chk(gnt_n, 8'hF);
  endtask : t_master
  task automatic t_irq;
    logic [2:0] bi [3];
    logic [7:0] ty [3];
    bi = '{3'h0, 3'h5, 3'h6};
    ty = '{8'h60, 8'h69, 8'h68};
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      irq_en <= (k == 3) ? 7'h00 : 7'h7F;
      irq_n <= ~(7'h01 << bi[k % 3]);
      repeat (8) @(posedge clk);
      #1;
      chk(irq_req, k != 3);
      if (k != 3) chk(irq_type, ty[k]);
    end
    irq_n <= 7'h7F;
  endtask : t_irq
  task automatic t_par;
    @(posedge clk);
    fault <= 1'h1;
    repeat (8) @(posedge clk);
    #1;
    chk({nmi, poff}, 8'h3);
    fault <= 1'h0;
    repeat (8) @(posedge clk);
    nmi_clear <= 1'h1;
    @(posedge clk);
    nmi_clear <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    chk(nmi, 0);
    @(posedge clk);
    onb <= 1'h1;
    @(posedge clk);
    onb <= 1'h0;
    #1;
    chk({nmi, poff}, 8'h2);
  endtask : t_par
  // Keyboard break first, then the rear button; each gives one reset pulse.
  task automatic t_rst;
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      {kbd, btn} <= k[0] ? 2'h1 : 2'h2;
      repeat (8) @(posedge clk);
      #1;
      chk(sys_rst_n, 0);
      @(posedge clk);
      {kbd, btn} <= 2'h0;
      repeat (260) @(posedge clk);
      #1;
      chk(sys_rst_n, 1);
    end
  endtask : t_rst
  task automatic t_ref;
    logic [7:0] row;
    for (k = 0; k < 2; k++) begin
      for (n = 0; n < 4000 && ref_n !== 1'h0; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      #1;
      if (k == 1) chk(addr_out[7:0], row + 8'h01);
      row = addr_out[7:0];
      repeat (80) @(posedge clk);
    end
  endtask : t_ref
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (240) @(posedge clk);
    #1;
    chk(sys_rst_n, 0);
    repeat (30) @(posedge clk);
    #1;
    chk(sys_rst_n, 1);
    t_mem();
    t_io();
    t_master();
    t_irq();
    t_par();
    t_rst();
    t_ref();
    final_report();
  end
endmodule : tb_option_bus_main_board_side
